// ===== verilog/mrd_regbank.sv
// Operation
// - Check byte zero at power-on, then held.
// - Transmitter status live only in Normal mode.
// - Bus wake flag and enable zero, then held.
// - Data mask bytes all ones, then held.
// - Length code zero at power-on, then held.
// - Correction and programmed status always live.
// - Forced-normal config always from nonvolatile store.
// - Forced-normal status zero, then live.
// - Scratch and identifier bytes zero, then held.
// - Extended-identifier select zero, then held.
// - Limp-home set by counter in Reset, by delay in Reset or Overtemp.
// - Group lock bits zero, then held.
// - Mode field set on entering Standby, Normal or Sleep.
// - Normal status one at power-on, cleared entering Normal.
// - Watchdog period 0100 at power-on and Overtemp.
// - Overheat flag and enable zero, then held.
// - Partial-net status zero, then live.
// - Mode change discards a concurrent register write.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mrd_regbank
  import mrd_pkg::*;
#(
  parameter logic [7:0] VARIANT_IDENT = 8'h5A  // Arbitrary value.
)(
  input  wire logic         CLOCK,
  input  wire logic         RSTN,
  input  wire logic         CE,
  input  wire logic [6:0]   AVS_ADDRESS,
  input  wire logic         AVS_READ,
  input  wire logic         AVS_WRITE,
  input  wire logic [3:0]   AVS_BYTEENABLE,
  input  wire logic [31:0]  AVS_WRITEDATA,
  output logic [31:0]       AVS_READDATA,
  output logic              AVS_WAITREQUEST,
  input  wire mrd_mode_type MODE_IN,
  input  wire logic         TX_LIVE,
  input  wire logic         PN_LIVE,
  input  wire logic         FORCED_NORMAL_LIVE,
  input  wire logic         ECC_LIVE,
  input  wire logic         NV_PROG_LIVE,
  input  wire logic         NV_FORCED_NORMAL_CFG,
  input  wire logic [1:0]   RESET_COUNTER,
  input  wire logic         LIMP_DELAY_DONE,
  input  wire logic         BUS_WAKE_EVT,
  input  wire logic         OVERHEAT_WARN_EVT,
  output logic [2:0]        OP_MODE_FIELD,
  output logic [3:0]        WATCHDOG_PERIOD_FIELD,
  output logic              LIMP_HOME_CTRL
);

  mrd_mode_type             cur_mode;
  logic                     entry;
  logic                     changing;
  logic                     hold_bus;
  logic                     wr_ok;
  logic [7:0]               wdata;
  logic [7:0]               next_rdata;
  logic [7:0]               nv_check_byte;
  logic                     trx_status;
  logic                     partial_net_status;
  logic                     forced_normal_status;
  logic                     err_correct_status;
  logic                     nv_programmed_status;
  logic                     bus_wake_flag;
  logic                     bus_wake_flag_en;
  logic                     overheat_warn_flag;
  logic                     overheat_warn_en;
  logic                     normal_entered_status;
  logic [LOCK_WIDTH-1:0]    group_lock_bits;
  logic                     ident_ext_sel;
  logic [3:0]               length_code;
  logic [7:0]               wake_data_mask_bytes   [0:NUM_DMASK-1];
  logic [7:0]               scratch_memory_bytes   [0:NUM_QUAD-1];
  logic [7:0]               wake_frame_ident_bytes [0:NUM_QUAD-1];

  mrd_mode_track u_mode (
    .clock    (CLOCK),
    .rstn     (RSTN),
    .ce       (CE),
    .mode_in  (MODE_IN),
    .mode     (cur_mode),
    .entry    (entry),
    .changing (changing)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Avalon slave. The answer comes one cycle after the request is seen, unless a mode change
  // holds it off; a write lands at the edge where waitrequest is sampled low.

  assign hold_bus = entry | changing;
  assign wdata    = AVS_WRITEDATA[7:0];
  // A write racing a mode change is dropped, since the change has priority.
  assign wr_ok    = !AVS_WAITREQUEST && AVS_WRITE && AVS_BYTEENABLE[0] && !hold_bus;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else if (CE) begin
      if (!AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && !hold_bus) begin
        AVS_WAITREQUEST <= 1'b0;
        AVS_READDATA    <= {24'h000000, next_rdata};
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (AVS_READ) begin
      case (AVS_ADDRESS)
        IDX_WDOG:     next_rdata = {4'h0, WATCHDOG_PERIOD_FIELD};
        IDX_MODE:     next_rdata = {5'h00, OP_MODE_FIELD};
        IDX_LIMP:     next_rdata = {7'h00, LIMP_HOME_CTRL};
        IDX_MAIN:     next_rdata = {6'h00, forced_normal_status, normal_entered_status};
        IDX_HEAT_EN:  next_rdata = {5'h00, overheat_warn_en, 2'h0};
        IDX_LOCK:     next_rdata = {1'b0, group_lock_bits};
        IDX_TRX_STAT: next_rdata = {trx_status, 1'b0, partial_net_status, 5'h00};
        IDX_WAKE_EN:  next_rdata = {7'h00, bus_wake_flag_en};
        IDX_FRAME:    next_rdata = {ident_ext_sel, 3'h0, length_code};
        IDX_SYS_EVT:  next_rdata = {5'h00, overheat_warn_flag, 2'h0};
        IDX_TRX_EVT:  next_rdata = {7'h00, bus_wake_flag};
        IDX_NV_STAT:  next_rdata = {6'h00, err_correct_status, nv_programmed_status};
        IDX_SBC_CFG:  next_rdata = {4'h0, NV_FORCED_NORMAL_CFG, 3'h0};
        IDX_CRC:      next_rdata = nv_check_byte;
        IDX_VARIANT:  next_rdata = VARIANT_IDENT;
        default: begin
          if (AVS_ADDRESS >= IDX_DMASK && AVS_ADDRESS < IDX_NV_STAT) begin
            next_rdata = wake_data_mask_bytes[AVS_ADDRESS[2:0]];
          end else if (AVS_ADDRESS >= IDX_SCRATCH && AVS_ADDRESS < IDX_LOCK) begin
            next_rdata = scratch_memory_bytes[AVS_ADDRESS[1:0] - 2'h2];
          end else if (AVS_ADDRESS >= IDX_IDENT && AVS_ADDRESS < 7'h2B) begin
            next_rdata = wake_frame_ident_bytes[AVS_ADDRESS[1:0] - 2'h3];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Mode-driven control fields.

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      OP_MODE_FIELD <= MF_STANDBY;
    end else if (CE) begin
      if (entry) begin
        case (cur_mode)
          MRD_STANDBY: OP_MODE_FIELD <= MF_STANDBY;
          MRD_NORMAL:  OP_MODE_FIELD <= MF_NORMAL;
          MRD_SLEEP:   OP_MODE_FIELD <= MF_SLEEP;
          default:     OP_MODE_FIELD <= OP_MODE_FIELD;
        endcase
      end else if (wr_ok && AVS_ADDRESS == IDX_MODE) begin
        OP_MODE_FIELD <= wdata[2:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WATCHDOG_PERIOD_FIELD <= RST_WDOG;
    end else if (CE) begin
      if (entry && cur_mode == MRD_OVERTEMP) begin
        WATCHDOG_PERIOD_FIELD <= RST_WDOG;
      end else if (wr_ok && AVS_ADDRESS == IDX_WDOG) begin
        WATCHDOG_PERIOD_FIELD <= wdata[3:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      normal_entered_status <= 1'b1;
    end else if (CE && entry && cur_mode == MRD_NORMAL) begin
      normal_entered_status <= 1'b0;
    end
  end

  // Hardware setting wins over a software clear in the same cycle.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      LIMP_HOME_CTRL <= 1'b0;
    end else if (CE) begin
      if ((cur_mode == MRD_RESET && (RESET_COUNTER == RST_CNT_LIMP || LIMP_DELAY_DONE)) ||
          (cur_mode == MRD_OVERTEMP && LIMP_DELAY_DONE)) begin
        LIMP_HOME_CTRL <= 1'b1;
      end else if (wr_ok && AVS_ADDRESS == IDX_LIMP) begin
        LIMP_HOME_CTRL <= wdata[BIT_LIMP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Live status. Off mode holds from power-on until another mode is reported, and returns whenever Off is reported.

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      trx_status           <= 1'b0;
      partial_net_status   <= 1'b0;
      forced_normal_status <= 1'b0;
      err_correct_status   <= 1'b0;
      nv_programmed_status <= 1'b0;
    end else if (CE) begin
      trx_status           <= (cur_mode == MRD_NORMAL) && TX_LIVE;
      partial_net_status   <= (cur_mode != MRD_OFF) && PN_LIVE;
      forced_normal_status <= (cur_mode != MRD_OFF) && FORCED_NORMAL_LIVE;
      err_correct_status   <= ECC_LIVE;
      nv_programmed_status <= NV_PROG_LIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Event flags: written one clears, an event in the same cycle wins.

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bus_wake_flag      <= 1'b0;
      overheat_warn_flag <= 1'b0;
    end else if (CE) begin
      if (BUS_WAKE_EVT) begin
        bus_wake_flag <= 1'b1;
      end else if (wr_ok && AVS_ADDRESS == IDX_TRX_EVT && wdata[BIT_BUS_WAKE]) begin
        bus_wake_flag <= 1'b0;
      end
      if (OVERHEAT_WARN_EVT) begin
        overheat_warn_flag <= 1'b1;
      end else if (wr_ok && AVS_ADDRESS == IDX_SYS_EVT && wdata[BIT_OVERHEAT]) begin
        overheat_warn_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Software-owned bits: set only at reset, never touched by mode entry.

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      nv_check_byte    <= RST_CRC;
      bus_wake_flag_en <= 1'b0;
      overheat_warn_en <= 1'b0;
      group_lock_bits  <= '0;
      ident_ext_sel    <= 1'b0;
      length_code      <= RST_DLC;
    end else if (CE && wr_ok) begin
      case (AVS_ADDRESS)
        IDX_CRC:    nv_check_byte    <= wdata;
        IDX_WAKE_EN: bus_wake_flag_en <= wdata[BIT_BUS_WAKE];
        IDX_HEAT_EN: overheat_warn_en <= wdata[BIT_OVERHEAT];
        IDX_LOCK:   group_lock_bits  <= wdata[LOCK_WIDTH-1:0];
        IDX_FRAME: begin
          ident_ext_sel <= wdata[BIT_IDE];
          length_code   <= wdata[3:0];
        end
        default: begin
          nv_check_byte <= nv_check_byte;
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DMASK; gi++) begin : g_byte
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          wake_data_mask_bytes[gi] <= RST_DMASK;
        end else if (CE && wr_ok && AVS_ADDRESS == IDX_DMASK + 7'(gi)) begin
          wake_data_mask_bytes[gi] <= wdata;
        end
      end
      if (gi < NUM_QUAD) begin : g_quad
        always_ff @(posedge CLOCK or negedge RSTN) begin
          if (!RSTN) begin
            scratch_memory_bytes[gi]   <= RST_BYTE;
            wake_frame_ident_bytes[gi] <= RST_BYTE;
          end else if (CE && wr_ok) begin
            if (AVS_ADDRESS == IDX_SCRATCH + 7'(gi)) begin
              scratch_memory_bytes[gi] <= wdata;
            end
            if (AVS_ADDRESS == IDX_IDENT + 7'(gi)) begin
              wake_frame_ident_bytes[gi] <= wdata;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_crc_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && entry |=> $stable(nv_check_byte))
    else $error("check byte changed on mode entry");

  a_tx_gate: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && cur_mode != MRD_NORMAL |=> !trx_status)
    else $error("transmitter status shown outside Normal");

  a_wake_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && BUS_WAKE_EVT |=> bus_wake_flag)
    else $error("bus wake event lost");

  a_mask_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && entry |=> $stable(wake_data_mask_bytes[0]) && $stable(length_code))
    else $error("mask or length code changed on mode entry");

  a_limp_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && cur_mode == MRD_RESET && RESET_COUNTER == RST_CNT_LIMP |=> LIMP_HOME_CTRL)
    else $error("limp-home not set at counter limit");

  a_mode_normal: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && entry && cur_mode == MRD_NORMAL |=> OP_MODE_FIELD == MF_NORMAL && !normal_entered_status)
    else $error("Normal entry defaults wrong");

  a_wdog_ot: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && entry && cur_mode == MRD_OVERTEMP |=> WATCHDOG_PERIOD_FIELD == RST_WDOG)
    else $error("watchdog period not reloaded in Overtemp");

  a_entry_stall: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && hold_bus && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("access answered during mode entry");

  a_ack_pulse: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");

  c_normal_entry: cover property (@(posedge CLOCK) disable iff (!RSTN)
    entry && cur_mode == MRD_NORMAL);

  c_read_done: cover property (@(posedge CLOCK) disable iff (!RSTN)
    AVS_READ && !AVS_WAITREQUEST);

  c_limp_rise: cover property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(LIMP_HOME_CTRL));

endmodule : mrd_regbank

// ===== verilog/mrd_pkg.sv
package mrd_pkg;

  typedef enum logic [2:0] {
    MRD_OFF      = 3'b000,
    MRD_SLEEP    = 3'b001,
    MRD_OVERTEMP = 3'b010,
    MRD_RESET    = 3'b011,
    MRD_STANDBY  = 3'b100,
    MRD_NORMAL   = 3'b111
  } mrd_mode_type;

  // Register indices; the Avalon word address equals the index.
  localparam logic [6:0] IDX_WDOG     = 7'h00;
  localparam logic [6:0] IDX_MODE     = 7'h01;
  localparam logic [6:0] IDX_LIMP     = 7'h02;
  localparam logic [6:0] IDX_MAIN     = 7'h03;
  localparam logic [6:0] IDX_HEAT_EN  = 7'h04;
  localparam logic [6:0] IDX_SCRATCH  = 7'h06;
  localparam logic [6:0] IDX_LOCK     = 7'h0A;
  localparam logic [6:0] IDX_TRX_STAT = 7'h22;
  localparam logic [6:0] IDX_WAKE_EN  = 7'h23;
  localparam logic [6:0] IDX_IDENT    = 7'h27;
  localparam logic [6:0] IDX_FRAME    = 7'h2F;
  localparam logic [6:0] IDX_SYS_EVT  = 7'h61;
  localparam logic [6:0] IDX_TRX_EVT  = 7'h63;
  localparam logic [6:0] IDX_DMASK    = 7'h68;
  localparam logic [6:0] IDX_NV_STAT  = 7'h70;
  localparam logic [6:0] IDX_SBC_CFG  = 7'h74;
  localparam logic [6:0] IDX_CRC      = 7'h75;
  localparam logic [6:0] IDX_VARIANT  = 7'h7E;

  // Field positions.
  localparam int BIT_LIMP     = 0;
  localparam int BIT_NORM_ENT   = 0;
  localparam int BIT_FORCED_ST  = 1;
  localparam int BIT_OVERHEAT   = 2;
  localparam int BIT_BUS_WAKE   = 0;
  localparam int BIT_CTS        = 7;
  localparam int BIT_PART_NET   = 5;
  localparam int BIT_IDE        = 7;
  localparam int BIT_ECC_ST     = 1;
  localparam int BIT_PROG_ST    = 0;
  localparam int BIT_FORCED_CFG = 3;
  localparam int LOCK_WIDTH   = 7;

  // Reset and mode-entry values.
  localparam logic [7:0] RST_CRC      = 8'h00;
  localparam logic [7:0] RST_DMASK    = 8'hFF;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [3:0] RST_DLC      = 4'h0;
  localparam logic [2:0] MF_STANDBY   = 3'h4;
  localparam logic [2:0] MF_NORMAL    = 3'h7;
  localparam logic [2:0] MF_SLEEP     = 3'h1;
  localparam logic [3:0] RST_WDOG     = 4'h4;
  localparam logic [1:0] RST_CNT_LIMP = 2'h3;
  localparam int         NUM_DMASK    = 8;
  localparam int         NUM_QUAD     = 4;

endpackage : mrd_pkg

// ===== verilog/mrd_mode_track.sv
`timescale 1ns/1ps
module mrd_mode_track
  import mrd_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire mrd_mode_type mode_in,
  output mrd_mode_type      mode,
  output logic              entry,
  output logic              changing
);

  // Unknown codes are ignored, so they must not hold the register bus off either.
  assign changing = (mode_in != mode) &&
                    (mode_in inside {MRD_OFF, MRD_SLEEP, MRD_OVERTEMP,
                                     MRD_RESET, MRD_STANDBY, MRD_NORMAL});

  // Entry pulses for one cycle after the current mode has been updated.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode  <= MRD_OFF;
      entry <= 1'b0;
    end else if (ce) begin
      entry <= 1'b0;
      if (changing) begin
        case (mode_in)
          MRD_OFF, MRD_SLEEP, MRD_OVERTEMP, MRD_RESET, MRD_STANDBY, MRD_NORMAL: begin
            mode  <= mode_in;
            entry <= 1'b1;
          end
          default: begin
            mode <= mode;
          end
        endcase
      end
    end
  end

endmodule : mrd_mode_track

// ===== sim/mrd_regbank_tb.sv
`timescale 1ns/1ps
module mrd_regbank_tb
  import mrd_pkg::*;
;
  localparam logic [7:0] VAR_CODE = 8'h3C;  // Arbitrary value.
  logic         clock, rstn, ce, avs_read, avs_write, avs_waitrequest;
  logic         tx_live, pn_live, fn_live, ecc_live, nv_prog_live, nv_fn_cfg;
  logic         limp_delay_done, bus_wake_evt, overheat_warn_evt, limp_home_ctrl;
  logic [6:0]   avs_address;
  logic [3:0]   avs_byteenable, wdog_field;
  logic [31:0]  avs_writedata, avs_readdata, seed;
  logic [1:0]   reset_counter;
  logic [2:0]   op_mode_field;
  mrd_mode_type mode_in;
  logic [7:0]   rd_val, mf_exp, wd_exp, ne_exp;
  int           bad_count, n_tests;
  // Every byte-wide store that must survive mode changes, with its implemented bits.
  logic [6:0] st_addr [0:20] = '{7'h75, 7'h06, 7'h07, 7'h08, 7'h09, 7'h27, 7'h28, 7'h29,
    7'h2A, 7'h68, 7'h69, 7'h6A, 7'h6B, 7'h6C, 7'h6D, 7'h6E, 7'h6F, 7'h0A, 7'h2F, 7'h23, 7'h04};
  logic [7:0] st_mask [0:20] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h8F, 8'h01, 8'h04};
  logic [7:0] st_exp  [0:20] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  mrd_mode_type modes [0:5] = '{MRD_STANDBY, MRD_NORMAL, MRD_SLEEP, MRD_OVERTEMP, MRD_RESET,
    MRD_STANDBY};

  mrd_regbank #(.VARIANT_IDENT(VAR_CODE)) dut (
    .CLOCK(clock), .RSTN(rstn), .CE(ce), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_BYTEENABLE(avs_byteenable), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .MODE_IN(mode_in),
    .TX_LIVE(tx_live), .PN_LIVE(pn_live), .FORCED_NORMAL_LIVE(fn_live), .ECC_LIVE(ecc_live),
    .NV_PROG_LIVE(nv_prog_live), .NV_FORCED_NORMAL_CFG(nv_fn_cfg),
    .RESET_COUNTER(reset_counter), .LIMP_DELAY_DONE(limp_delay_done),
    .BUS_WAKE_EVT(bus_wake_evt), .OVERHEAT_WARN_EVT(overheat_warn_evt),
    .OP_MODE_FIELD(op_mode_field), .WATCHDOG_PERIOD_FIELD(wdog_field),
    .LIMP_HOME_CTRL(limp_home_ctrl));

  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction : lfsr

  // Overtemp and Reset entries leave the software-written mode field alone.
  function automatic logic [7:0] field_for(input mrd_mode_type m, input logic [7:0] keep);
    case (m)
      MRD_STANDBY: field_for = 8'h04;
      MRD_NORMAL:  field_for = 8'h07;
      MRD_SLEEP:   field_for = 8'h01;
      default:     field_for = keep;
    endcase
  endfunction : field_for

  task automatic miss(input string what);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, what);
  endtask : miss

  task automatic chk_reg(input logic [6:0] a, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) miss($sformatf("reg %0h read %0h expected %0h", a, got, exp));
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) miss($sformatf("%s is %0h expected %0h", what, got, exp));
  endtask : chk_pin

  // One Avalon transfer: request held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 200) begin
      n++;
      @(posedge clock);
    end
    if (n >= 200) miss("bus transfer never answered");
    rd_val = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input logic [7:0] mask);
    bus(1'b0, a, 8'h00, 4'hF);
    chk_reg(a, rd_val & mask, exp);
  endtask : rd_chk

  task automatic check_store();
    for (int i = 0; i < 21; i++) rd_chk(st_addr[i], st_exp[i], st_mask[i]);
  endtask : check_store

  task automatic set_mode(input mrd_mode_type m);
    mode_in <= m;
    repeat (4) @(posedge clock);
  endtask : set_mode

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    miss("watchdog expired");
    test_done();
  end

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {tx_live, pn_live, fn_live, ecc_live, nv_prog_live, nv_fn_cfg} = 6'h3F;
    {reset_counter, limp_delay_done, bus_wake_evt, overheat_warn_evt} = '0;
    mode_in = MRD_OFF;
    seed = 32'h607C;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    // Power-on values; live inputs are all high yet Off must hide some of them.
    chk_pin("mode field", {5'h0, op_mode_field}, 8'h04);
    chk_pin("watchdog field", {4'h0, wdog_field}, 8'h04);
    chk_pin("limp", {7'h0, limp_home_ctrl}, 8'h00);
    check_store();
    rd_chk(IDX_MAIN, 8'h01, 8'h03);
    rd_chk(IDX_TRX_STAT, 8'h00, 8'hA0);
    rd_chk(IDX_NV_STAT, 8'h03, 8'h03);
    rd_chk(IDX_SBC_CFG, 8'h08, 8'h08);
    rd_chk(IDX_VARIANT, VAR_CODE, 8'hFF);
    rd_chk(IDX_SYS_EVT, 8'h00, 8'h04);
    rd_chk(IDX_TRX_EVT, 8'h00, 8'h01);
    rd_chk(7'h50, 8'h00, 8'hFF);
    for (int i = 0; i < 21; i++) begin
      seed = lfsr(seed);
      st_exp[i] = seed[7:0] & st_mask[i];
      wr(st_addr[i], seed[7:0]);
    end
    bus(1'b1, IDX_CRC, ~st_exp[0], 4'h0);
    mf_exp = 8'h04;
    ne_exp = 8'h01;
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      wr(IDX_WDOG, {4'h0, seed[11:8]});
      wr(IDX_MODE, {5'h0, seed[14:12]});
      wd_exp = (modes[k] == MRD_OVERTEMP) ? 8'h04 : {4'h0, seed[11:8]};
      mf_exp = field_for(modes[k], {5'h0, seed[14:12]});
      if (modes[k] == MRD_NORMAL) ne_exp = 8'h00;
      {tx_live, pn_live, fn_live, ecc_live, nv_prog_live, nv_fn_cfg} <= seed[21:16];
      set_mode(modes[k]);
      check_store();
      rd_chk(IDX_MODE, mf_exp, 8'h07);
      chk_pin("mode field", {5'h0, op_mode_field}, mf_exp);
      rd_chk(IDX_WDOG, wd_exp, 8'h0F);
      chk_pin("watchdog field", {4'h0, wdog_field}, wd_exp);
      rd_chk(IDX_MAIN, {6'h0, fn_live, ne_exp[0]}, 8'h03);
      rd_chk(IDX_TRX_STAT, {tx_live && modes[k] == MRD_NORMAL, 1'b0, pn_live, 5'h0},
             8'hA0);
      rd_chk(IDX_NV_STAT, {6'h0, ecc_live, nv_prog_live}, 8'h03);
      rd_chk(IDX_SBC_CFG, {4'h0, nv_fn_cfg, 3'h0}, 8'h08);
      rd_chk(IDX_VARIANT, VAR_CODE, 8'hFF);
    end
    // Limp-home: counter at 3 in Reset, delay in Reset and Overtemp, ignored in Standby.
    set_mode(MRD_RESET);
    reset_counter <= 2'h3;
    repeat (3) @(posedge clock);
    chk_pin("limp", {7'h0, limp_home_ctrl}, 8'h01);
    reset_counter <= 2'h2;
    wr(IDX_LIMP, 8'h00);
    rd_chk(IDX_LIMP, 8'h00, 8'h01);
    limp_delay_done <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(IDX_LIMP, 8'h01, 8'h01);
    limp_delay_done <= 1'b0;
    set_mode(MRD_OVERTEMP);
    wr(IDX_LIMP, 8'h00);
    limp_delay_done <= 1'b1;
    repeat (3) @(posedge clock);
    chk_pin("limp", {7'h0, limp_home_ctrl}, 8'h01);
    limp_delay_done <= 1'b0;
    set_mode(MRD_STANDBY);
    wr(IDX_LIMP, 8'h00);
    limp_delay_done <= 1'b1;
    reset_counter <= 2'h3;
    repeat (3) @(posedge clock);
    chk_pin("limp", {7'h0, limp_home_ctrl}, 8'h00);
    {limp_delay_done, reset_counter} <= 3'h0;
    // Event flags latch, survive a mode change and clear on a written one.
    bus_wake_evt <= 1'b1;
    overheat_warn_evt <= 1'b1;
    @(posedge clock);
    {bus_wake_evt, overheat_warn_evt} <= 2'h0;
    set_mode(MRD_NORMAL);
    rd_chk(IDX_TRX_EVT, 8'h01, 8'h01);
    rd_chk(IDX_SYS_EVT, 8'h04, 8'h04);
    bus_wake_evt <= 1'b1;
    wr(IDX_TRX_EVT, 8'h01);
    bus_wake_evt <= 1'b0;
    rd_chk(IDX_TRX_EVT, 8'h01, 8'h01);
    wr(IDX_TRX_EVT, 8'h01);
    wr(IDX_SYS_EVT, 8'h04);
    rd_chk(IDX_TRX_EVT, 8'h00, 8'h01);
    rd_chk(IDX_SYS_EVT, 8'h00, 8'h04);
    // A write taken just before a mode change completes but must not land.
    avs_address <= st_addr[1];
    avs_writedata <= {24'h0, ~st_exp[1]};
    avs_write <= 1'b1;
    @(posedge clock);
    mode_in <= MRD_SLEEP;
    bus(1'b1, st_addr[1], ~st_exp[1], 4'hF);
    rd_chk(st_addr[1], st_exp[1], 8'hFF);
    // A read raised with a mode change sees the new entry value.
    mode_in <= MRD_STANDBY;
    rd_chk(IDX_MODE, 8'h04, 8'h07);
    // A frozen block ignores events; an unknown mode code must not stall the bus.
    ce <= 1'b0;
    bus_wake_evt <= 1'b1;
    repeat (3) @(posedge clock);
    {ce, bus_wake_evt} <= 2'b10;
    mode_in <= mrd_mode_type'(3'b101);
    rd_chk(IDX_TRX_EVT, 8'h00, 8'h01);
    rd_chk(IDX_MODE, 8'h04, 8'h07);
    // A second reset in mid-run restores the power-on values.
    mode_in <= MRD_OFF;
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    rd_chk(IDX_CRC, 8'h00, 8'hFF);
    rd_chk(IDX_DMASK, 8'hFF, 8'hFF);
    rd_chk(IDX_MAIN, 8'h01, 8'h03);
    chk_pin("watchdog field", {4'h0, wdog_field}, 8'h04);
    test_done();
  end
endmodule : mrd_regbank_tb
